// ===== rtl/sadc_conversion_control.sv
// Conversion control for a 10-bit successive approximation converter.
// Assumes a byte-wide register port driven on sys_clk, trigger sources and
// the power reduction bit generated on sys_clk, and an analog array that
// presents its 10-bit result by the completion cycle.
//
// Behaviour
// - Ten-bit result in two bytes, right aligned unless left align is set.
// - Reading the low byte blocks result updates until the high byte read.
// - A completion while blocked leaves both bytes unchanged, result discarded.
// - Reading the high byte re-enables result updates.
// - Completion flag and pulse still occur when the result is discarded.
// - Channel and reference selections apply only while the converter is enabled.
// - Writing start begins a conversion; bit stays set until it finishes.
// - A channel change mid-conversion waits for the current conversion's end.
// - Auto-trigger rising edge resets the prescaler and starts a conversion.
// - Trigger held high or edges during conversion start nothing new.
// - Flags set regardless of enables; a flag trigger restarts with the flag still set.
// - Completion flag as trigger gives free running after a software start.
// - Start write launches a conversion with auto-trigger on; start reads busy.
// - Prescaler counts while enabled and is held reset while disabled.
// - Software start begins at the next converter clock rising edge.
// - Normal conversion lasts 13 converter cycles, the first one 25.
// - Sampling at 1.5 cycles normally, at 13.5 cycles for the first.
// - Completion writes result, sets flag, clears start in single mode.
// - Auto-triggered: sample at 2 cycles, 13.5 cycle conversion, 3 sync cycles.
// - Free running restarts at once after each completion, start stays set.
// - Selections track writes until start, lock, then resume in last cycle.
`timescale 1ns/1ns
`default_nettype none

module sadc_conversion_control
    import sadc_pkg::*;
#(
    parameter int NUM_TRIG = 8
) (
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Register port.
    input  wire logic [2:0]            regAddr,
    input  wire logic [7:0]            regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [7:0]            regRdata,
    // Trigger sources and power reduction.
    input  wire logic [NUM_TRIG-1:0]   trigSources,
    input  wire logic                  pwrReduce,
    // Analog sample-and-hold and comparator array.
    input  wire logic [9:0]            anaResult,
    output logic                       anaEnable,
    output logic                       anaStart,
    output logic                       anaSample,
    output logic [3:0]                 anaChannel,
    output logic [1:0]                 anaReference,
    // Completion indication.
    output logic                       convDone,
    output logic                       completeFlag
);
    import sadc_pkg::*;

    // Software registers.
    logic                   enable_r;
    logic                   auto_r;
    logic [SADC_PS_W-1:0]   prescale_r;
    logic [SADC_TSRC_W-1:0] trigSrc_r;
    logic [SADC_CH_W-1:0]   channelSel_r;
    logic [SADC_REF_W-1:0]  referenceSel_r;
    logic                   leftAlign_r;
    logic                   flag_r;

    // Conversion state.
    sadc_state_t state_r;
    logic [7:0]  presCnt_r;
    logic [5:0]  halfCnt_r;
    logic        first_r;
    logic        autoConv_r;
    logic        lock_r;
    logic [9:0]  result_r;
    logic [2:0]  trigDly_r;
    logic        sampled_r;
    logic [3:0]  chanApplied_r;
    logic [1:0]  refApplied_r;
    logic [7:0]  rdata_r;

    logic       effEnable;
    logic [7:0] presLast;
    logic [7:0] presHalf;
    logic       convTick;
    logic       halfEvt;
    logic       startWr;
    logic       trigSel;
    logic       trigEdge;
    logic       trigStart;
    logic       freeRun;
    logic       busy;
    logic       lastPhase;
    logic [5:0] curSample;
    logic [5:0] curDone;
    logic       rdLow;
    logic       rdHigh;

    // The converter only runs when software has lifted power reduction.
    assign effEnable = enable_r & ~pwrReduce;
    assign anaEnable = effEnable;

    // Divide ratio is 2 << select, so the count runs 0 to ratio-1.
    assign presLast = 8'((9'h002 << prescale_r) - 9'h001);
    assign presHalf = 8'((9'h001 << prescale_r) - 9'h001);
    assign convTick = effEnable && (presCnt_r == presLast);
    assign halfEvt  = convTick || (effEnable && (presCnt_r == presHalf));

    assign startWr = regWr && (regAddr == SADC_CTRL_A_OFS) &&
                     regWdata[SADC_START_BIT];
    assign freeRun = auto_r && (trigSrc_r == SADC_TSRC_FLAG);
    assign busy    = (state_r != SADC_IDLE);

    // The completion flag source is handled by the restart path, not edges.
    assign trigSel  = (trigSrc_r == SADC_TSRC_FLAG) ? 1'b0 :
                      trigSources[trigSrc_r];
    assign trigEdge = trigDly_r[SADC_TRIG_SYNC-2] &
                      ~trigDly_r[SADC_TRIG_SYNC-1];
    // Edges while busy are dropped; a level still high gives no new edge.
    assign trigStart = effEnable && auto_r && trigEdge &&
                       (state_r == SADC_IDLE);

    assign curSample = first_r    ? SADC_FIRST_SAMPLE :
                       autoConv_r ? SADC_AUTO_SAMPLE : SADC_NORM_SAMPLE;
    assign curDone   = first_r    ? SADC_FIRST_DONE :
                       autoConv_r ? SADC_AUTO_DONE : SADC_NORM_DONE;
    assign lastPhase = (state_r == SADC_CONV) &&
                       (halfCnt_r >= curDone - 6'h02);

    assign convDone  = (state_r == SADC_CONV) && halfEvt &&
                       (halfCnt_r == curDone - 6'h01);
    assign anaSample = (state_r == SADC_CONV) && halfEvt && !sampled_r &&
                       (halfCnt_r == curSample - 6'h01);
    assign rdLow  = regRd && (regAddr == SADC_RES_LOW_OFS);
    assign rdHigh = regRd && (regAddr == SADC_RES_HIGH_OFS);

    assign anaChannel   = chanApplied_r;
    assign anaReference = refApplied_r;
    assign completeFlag = flag_r;
    assign regRdata     = rdata_r;

    // Software-written control fields.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable_r       <= SADC_CTRL_A_RST[SADC_EN_BIT];
            auto_r         <= SADC_CTRL_A_RST[SADC_AUTO_BIT];
            prescale_r     <= SADC_CTRL_A_RST[SADC_PS_LSB +: SADC_PS_W];
            trigSrc_r      <= SADC_CTRL_B_RST[SADC_TSRC_LSB +: SADC_TSRC_W];
            channelSel_r   <= SADC_CHREF_RST[SADC_CH_LSB +: SADC_CH_W];
            referenceSel_r <= SADC_CHREF_RST[SADC_REF_LSB +: SADC_REF_W];
            leftAlign_r    <= SADC_CHREF_RST[SADC_ALIGN_BIT];
        end else if (regWr) begin
            if (regAddr == SADC_CTRL_A_OFS) begin
                enable_r   <= regWdata[SADC_EN_BIT];
                auto_r     <= regWdata[SADC_AUTO_BIT];
                prescale_r <= regWdata[SADC_PS_LSB +: SADC_PS_W];
            end else if (regAddr == SADC_CTRL_B_OFS) begin
                trigSrc_r <= regWdata[SADC_TSRC_LSB +: SADC_TSRC_W];
            end else if (regAddr == SADC_CHREF_OFS) begin
                channelSel_r   <= regWdata[SADC_CH_LSB +: SADC_CH_W];
                referenceSel_r <= regWdata[SADC_REF_LSB +: SADC_REF_W];
                leftAlign_r    <= regWdata[SADC_ALIGN_BIT];
            end
        end
    end

    // Completion flag: set always wins over a write-one clear.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_r <= SADC_CTRL_A_RST[SADC_FLAG_BIT];
        end else if (convDone) begin
            flag_r <= 1'b1;
        end else if (regWr && (regAddr == SADC_CTRL_A_OFS) &&
                     regWdata[SADC_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    // Prescaler, held in reset while disabled and restarted by a trigger.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !effEnable) begin
            presCnt_r <= 8'h00;
        end else if (trigStart) begin
            presCnt_r <= 8'h00;
        end else if (presCnt_r >= presLast) begin
            presCnt_r <= 8'h00;
        end else begin
            presCnt_r <= presCnt_r + 8'h01;
        end
    end

    // Trigger delay line, giving the three cycles of synchronisation.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trigDly_r <= 3'h0;
        end else begin
            trigDly_r <= {trigDly_r[1:0], trigSel};
        end
    end

    // Conversion sequencer.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r    <= SADC_IDLE;
            halfCnt_r  <= 6'h00;
            autoConv_r <= 1'b0;
            sampled_r  <= 1'b0;
            anaStart   <= 1'b0;
        end else begin
            anaStart <= 1'b0;
            case (state_r)
                SADC_IDLE: begin
                    if (trigStart) begin
                        state_r    <= SADC_CONV;
                        halfCnt_r  <= 6'h00;
                        autoConv_r <= 1'b1;
                        sampled_r  <= 1'b0;
                        anaStart   <= 1'b1;
                    end else if (startWr && regWdata[SADC_EN_BIT] &&
                                 !pwrReduce) begin
                        state_r <= SADC_WAIT;
                    end
                end
                SADC_WAIT: begin
                    if (!effEnable) begin
                        state_r <= SADC_IDLE;
                    end else if (convTick) begin
                        state_r    <= SADC_CONV;
                        halfCnt_r  <= 6'h00;
                        autoConv_r <= 1'b0;
                        sampled_r  <= 1'b0;
                        anaStart   <= 1'b1;
                    end
                end
                SADC_CONV: begin
                    if (!effEnable) begin
                        state_r <= SADC_IDLE;
                    end else if (convDone) begin
                        halfCnt_r  <= 6'h00;
                        autoConv_r <= 1'b0;
                        sampled_r  <= 1'b0;
                        if (freeRun) begin
                            anaStart <= 1'b1;
                        end else begin
                            state_r <= SADC_IDLE;
                        end
                    end else if (halfEvt) begin
                        halfCnt_r <= halfCnt_r + 6'h01;
                        if (anaSample) begin
                            sampled_r <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= SADC_IDLE;
                end
            endcase
        end
    end

    // The first conversion after enabling takes the long timing.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !effEnable) begin
            first_r <= 1'b1;
        end else if (convDone) begin
            first_r <= 1'b0;
        end
    end

    // Selections are applied only while enabled, when not converting or in the last cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chanApplied_r <= SADC_CHREF_RST[SADC_CH_LSB +: SADC_CH_W];
            refApplied_r  <= SADC_CHREF_RST[SADC_REF_LSB +: SADC_REF_W];
        end else if (effEnable && (state_r != SADC_CONV || lastPhase)) begin
            chanApplied_r <= channelSel_r;
            refApplied_r  <= referenceSel_r;
        end
    end

    // Result lock between the low and the high byte read.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lock_r <= 1'b0;
        end else if (rdHigh) begin
            lock_r <= 1'b0;
        end else if (rdLow) begin
            lock_r <= 1'b1;
        end
    end

    // A completion while locked is lost, though the flag still sets.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_r <= 10'h000;
        end else if (convDone && !lock_r) begin
            result_r <= anaResult;
        end
    end

    // Read data, one cycle after the read strobe; unmapped reads as zero.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (regRd) begin
            if (regAddr == SADC_CTRL_A_OFS) begin
                rdata_r <= {enable_r, busy, auto_r, flag_r, 1'b0,
                            prescale_r};
            end else if (regAddr == SADC_CTRL_B_OFS) begin
                rdata_r <= {5'h00, trigSrc_r};
            end else if (regAddr == SADC_CHREF_OFS) begin
                rdata_r <= {referenceSel_r, leftAlign_r, 1'b0, channelSel_r};
            end else if (regAddr == SADC_RES_LOW_OFS) begin
                rdata_r <= leftAlign_r ? {result_r[1:0], 6'h00} :
                                         result_r[7:0];
            end else if (regAddr == SADC_RES_HIGH_OFS) begin
                rdata_r <= leftAlign_r ? result_r[9:2] :
                                         {6'h00, result_r[9:8]};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Checks on the sequencer and the software-visible state.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    start_read_a: assert property (
        regRd && regAddr == SADC_CTRL_A_OFS |=>
            regRdata[SADC_START_BIT] == $past(busy))
        else $error("start bit read does not show busy");

    lock_hold_a: assert property (
        convDone && lock_r && !rdHigh |=> $stable(result_r))
        else $error("result changed while locked");

    low_lock_a: assert property (
        rdLow && !rdHigh |=> lock_r)
        else $error("low byte read did not lock result");

    high_unlock_a: assert property (
        rdHigh |=> !lock_r)
        else $error("high byte read did not unlock result");

    flag_set_a: assert property (
        convDone |=> flag_r)
        else $error("completion did not set flag");

    chan_lock_a: assert property (
        state_r == SADC_CONV && !lastPhase && effEnable |=>
            $stable(chanApplied_r))
        else $error("channel changed mid conversion");

    pres_hold_a: assert property (
        !effEnable |=> presCnt_r == 8'h00)
        else $error("prescaler ran while disabled");

    single_end_a: assert property (
        convDone && !freeRun && effEnable |=> state_r == SADC_IDLE)
        else $error("single conversion did not end");

    free_run_a: assert property (
        convDone && freeRun && effEnable |=> state_r == SADC_CONV && busy)
        else $error("free running did not restart");

    trig_start_a: assert property (
        trigStart |=> state_r == SADC_CONV && presCnt_r == 8'h00)
        else $error("trigger did not start conversion");

    trig_ignore_a: assert property (
        state_r == SADC_CONV && trigEdge && !convDone |=> !anaStart)
        else $error("trigger edge during conversion started one");

    norm_len_a: assert property (
        disable iff (!rst_n || !effEnable || prescale_r != 3'h0)
        anaStart && !first_r && !autoConv_r |-> ##25 convDone)
        else $error("normal conversion length wrong");

    first_cov: cover property (convDone && first_r);
    lost_cov:  cover property (convDone && lock_r);
    free_cov:  cover property (convDone && freeRun);
    trig_cov:  cover property (trigStart);

endmodule : sadc_conversion_control

`default_nettype wire

// ===== rtl/sadc_pkg.sv
// Package for the successive approximation converter control block.
// Holds register offsets, field positions, reset values and the conversion
// timing counts shared by the design and by the verification side.
package sadc_pkg;

    // Register offsets on the plain byte-wide register port.
    localparam logic [2:0] SADC_CTRL_A_OFS   = 3'h0;
    localparam logic [2:0] SADC_CTRL_B_OFS   = 3'h1;
    localparam logic [2:0] SADC_CHREF_OFS    = 3'h2;
    localparam logic [2:0] SADC_RES_LOW_OFS  = 3'h3;
    localparam logic [2:0] SADC_RES_HIGH_OFS = 3'h4;

    // Fields of converter_control_a.
    localparam int SADC_EN_BIT    = 7;
    localparam int SADC_START_BIT = 6;
    localparam int SADC_AUTO_BIT  = 5;
    localparam int SADC_FLAG_BIT  = 4;
    localparam int SADC_PS_LSB    = 0;
    localparam int SADC_PS_W      = 3;

    // Fields of converter_control_b and channel_reference_control.
    localparam int SADC_TSRC_LSB  = 0;
    localparam int SADC_TSRC_W    = 3;
    localparam int SADC_REF_LSB   = 6;
    localparam int SADC_REF_W     = 2;
    localparam int SADC_ALIGN_BIT = 5;
    localparam int SADC_CH_LSB    = 0;
    localparam int SADC_CH_W      = 4;

    // Reset values of the writable registers.
    localparam logic [7:0] SADC_CTRL_A_RST = 8'h00;
    localparam logic [7:0] SADC_CTRL_B_RST = 8'h00;
    localparam logic [7:0] SADC_CHREF_RST  = 8'h00;

    // Trigger source code that selects the completion flag (free running).
    localparam logic [2:0] SADC_TSRC_FLAG = 3'h0;

    // Conversion timing in half converter clock cycles from the start edge.
    localparam logic [5:0] SADC_NORM_SAMPLE  = 6'h03;  // 1.5 cycles
    localparam logic [5:0] SADC_NORM_DONE    = 6'h1a;  // 13 cycles
    localparam logic [5:0] SADC_FIRST_SAMPLE = 6'h1b;  // 13.5 cycles
    localparam logic [5:0] SADC_FIRST_DONE   = 6'h32;  // 25 cycles
    localparam logic [5:0] SADC_AUTO_SAMPLE  = 6'h04;  // 2 cycles
    localparam logic [5:0] SADC_AUTO_DONE    = 6'h1b;  // 13.5 cycles

    // CPU clock cycles spent synchronising a trigger edge.
    localparam int SADC_TRIG_SYNC = 3;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_WAIT = 2'b01,
        SADC_CONV = 2'b11
    } sadc_state_t;

endpackage : sadc_pkg

// ===== tb/sadc_analog_model.sv
// Behavioural analog array that answers the converter control block.
// Assumes one sample pulse per conversion, all on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module sadc_analog_model (
    // Clock.
    input  wire logic       sys_clk,
    // Control from the converter.
    input  wire logic       anaEnable,
    input  wire logic       anaSample,
    input  wire logic [3:0] anaChannel,
    // Result back to the converter.
    output logic      [9:0] anaResult
);
    logic [3:0] heldChannel_r;

    initial heldChannel_r = 4'h0;

    // The channel is caught at the sample moment, so a later change of the
    // selection cannot leak into this conversion's code.
    always @(posedge sys_clk) begin
        if (anaEnable && anaSample) begin
            heldChannel_r <= anaChannel;
        end
    end

    // Powered down, the array shows a toggling pattern rather than a level.
    assign anaResult = anaEnable ? {heldChannel_r, 6'h15}
                                 : (10'h2aa ^ {10{sys_clk}});
endmodule : sadc_analog_model

`default_nettype wire

// ===== tb/tb_sadc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes the analog model returns {channel at sample, 6'h15}.
`timescale 1ns/1ns
`default_nettype none

module tb_sadc_conversion_control;
    import sadc_pkg::*;
    logic       sys_clk, rst_n, regWr, regRd, pwrReduce;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata, trigSources;
    logic [9:0] anaResult;
    logic       anaEnable, anaStart, anaSample, convDone, completeFlag;
    logic [3:0] anaChannel;
    logic [1:0] anaReference;
    int         err_total, tests_run, cyc, tStart, tSample, tDone;
    int         nDone, nStart, nSample, latFirst, sampFirst, latNorm, sampNorm;

    sadc_conversion_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .trigSources(trigSources), .pwrReduce(pwrReduce),
        .anaResult(anaResult), .anaEnable(anaEnable), .anaStart(anaStart),
        .anaSample(anaSample), .anaChannel(anaChannel),
        .anaReference(anaReference), .convDone(convDone),
        .completeFlag(completeFlag));
    sadc_analog_model model_u (.sys_clk(sys_clk), .anaEnable(anaEnable),
        .anaSample(anaSample), .anaChannel(anaChannel), .anaResult(anaResult));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Pulse times are taken mid-cycle, where the outputs have settled.
    always @(negedge sys_clk) begin
        cyc++;
        if (anaStart) begin tStart = cyc; nStart++; end
        if (anaSample) begin tSample = cyc; nSample++; end
        if (convDone) begin tDone = cyc; nDone++; end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1 chk({2'h0, regRdata}, {2'h0, exp});
    endtask : rdc

    task automatic wait_done(input int n);
        for (int i = 0; i < 3000 && nDone < n; i++) @(negedge sys_clk);
        if (nDone < n) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, nDone, n);
            report_and_stop();
        end
    endtask : wait_done

    task automatic t_reset();
        rdc(SADC_CTRL_A_OFS, SADC_CTRL_A_RST);
        rdc(SADC_CTRL_B_OFS, SADC_CTRL_B_RST);
        rdc(SADC_CHREF_OFS, SADC_CHREF_RST);
        rdc(3'h5, 8'h00);
        chk({9'h000, anaEnable}, 10'h000);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_disabled();
        wr(SADC_CHREF_OFS, 8'h43);
        wr(SADC_CTRL_A_OFS, 8'h40);
        repeat (60) @(negedge sys_clk);
        chk(10'(nStart), 10'h000);
        chk({4'h0, anaReference, anaChannel}, 10'h000);
        rdc(SADC_CTRL_A_OFS, 8'h00);
        $display("test disabled finished");
    endtask : t_disabled

    task automatic t_first();
        // Power reduction stays low; ratio 2 trades resolution for run time.
        wr(SADC_CTRL_A_OFS, 8'hc0);
        rdc(SADC_CTRL_A_OFS, 8'hc0);
        chk({4'h0, anaReference, anaChannel}, 10'h013);
        wait_done(1);
        latFirst = tDone - tStart;
        sampFirst = tSample - tStart;
        rdc(SADC_CTRL_A_OFS, 8'h90);
        chk({9'h000, completeFlag}, 10'h001);
        rdc(SADC_RES_LOW_OFS, 8'hd5);
        rdc(SADC_RES_HIGH_OFS, 8'h00);
        $display("test first finished");
    endtask : t_first

    task automatic t_normal();
        wr(SADC_CHREF_OFS, 8'h25);
        wr(SADC_CTRL_A_OFS, 8'hd0);
        for (int i = 0; i < 200 && nSample < 2; i++) @(negedge sys_clk);
        if (nSample < 2) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, nSample, 2);
            report_and_stop();
        end
        wr(SADC_CHREF_OFS, 8'h27);
        wait_done(2);
        latNorm = tDone - tStart;
        sampNorm = tSample - tStart;
        chk(10'(latFirst - latNorm), 10'(SADC_FIRST_DONE - SADC_NORM_DONE));
        chk(10'(sampFirst - sampNorm),
            10'(SADC_FIRST_SAMPLE - SADC_NORM_SAMPLE));
        chk(10'(latNorm >= 25 && latNorm <= 27), 10'h001);
        rdc(SADC_CTRL_A_OFS, 8'h90);
        rdc(SADC_RES_LOW_OFS, 8'h40);
        rdc(SADC_RES_HIGH_OFS, 8'h55);
        chk({6'h00, anaChannel}, 10'h007);
        $display("test normal finished");
    endtask : t_normal

    task automatic t_lock();
        rdc(SADC_RES_LOW_OFS, 8'h40);
        wr(SADC_CTRL_A_OFS, 8'hd0);
        wait_done(3);
        rdc(SADC_CTRL_A_OFS, 8'h90);
        rdc(SADC_RES_HIGH_OFS, 8'h55);
        wr(SADC_CTRL_A_OFS, 8'hd0);
        wait_done(4);
        rdc(SADC_RES_LOW_OFS, 8'h40);
        rdc(SADC_RES_HIGH_OFS, 8'h75);
        $display("test lock finished");
    endtask : t_lock

    task automatic t_auto();
        wr(SADC_CHREF_OFS, 8'h01);
        wr(SADC_CTRL_B_OFS, 8'h01);
        wr(SADC_CTRL_A_OFS, 8'hb0);
        @(posedge sys_clk);
        trigSources <= 8'h02;
        wait_done(5);
        chk(10'(tDone - tStart - latNorm),
            10'(SADC_AUTO_DONE - SADC_NORM_DONE));
        chk(10'(tSample - tStart - sampNorm),
            10'(SADC_AUTO_SAMPLE - SADC_NORM_SAMPLE));
        repeat (80) @(negedge sys_clk);
        chk(10'(nDone), 10'h005);
        rdc(SADC_CTRL_A_OFS, 8'hb0);
        rdc(SADC_RES_LOW_OFS, 8'h55);
        rdc(SADC_RES_HIGH_OFS, 8'h00);
        trigSources <= 8'h00;
        wr(SADC_CTRL_A_OFS, 8'hf0);
        // An edge mid-conversion and a level held at completion start nothing.
        repeat (8) @(posedge sys_clk);
        trigSources <= 8'h02;
        wait_done(6);
        repeat (80) @(negedge sys_clk);
        chk(10'(nDone), 10'h006);
        rdc(SADC_CTRL_A_OFS, 8'hb0);
        trigSources <= 8'h00;
        $display("test auto finished");
    endtask : t_auto

    task automatic t_free();
        int n;
        wr(SADC_CTRL_B_OFS, 8'h00);
        wr(SADC_CTRL_A_OFS, 8'he0);
        wait_done(9);
        rdc(SADC_CTRL_A_OFS, 8'hf0);
        wr(SADC_CTRL_A_OFS, 8'h00);
        @(negedge sys_clk);
        n = nDone;
        repeat (80) @(negedge sys_clk);
        chk(10'(nDone - n), 10'h000);
        wr(SADC_CTRL_A_OFS, 8'h80);
        @(negedge sys_clk);
        chk({9'h000, anaEnable}, 10'h001);
        @(posedge sys_clk);
        pwrReduce <= 1'b1;
        @(negedge sys_clk);
        chk({9'h000, anaEnable}, 10'h000);
        $display("test free finished");
    endtask : t_free

    initial begin
        {rst_n, regWr, regRd, pwrReduce, regAddr, regWdata} = '0;
        trigSources = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_disabled();
        t_first();
        t_normal();
        t_lock();
        t_auto();
        t_free();
        report_and_stop();
    end
endmodule : tb_sadc_conversion_control

`default_nettype wire
